// >>> src/servo_rf_defines.svh
// Offsets, field positions, reset values and word framing for the control register bank
`ifndef SERVO_RF_DEFINES_SVH
`define SERVO_RF_DEFINES_SVH

// ==========================================================
// Register addresses (top nibble of each control word)
`define ADDR_RF_GAIN_SEL 4'h1
`define ADDR_FOCUS_OFFSET 4'h2
`define ADDR_RF_OFFS_LR 4'h4
`define ADDR_RF_OFFS_SUM 4'h5
`define ADDR_CHAN_SWITCH 4'h8
`define ADDR_RADIAL 4'hB
`define ADDR_CENTRAL_AB 4'hC
`define ADDR_CENTRAL_CD 4'hD
`define ADDR_RF_FILTER 4'hE
`define ADDR_PHASE_FILTER 4'hF
`define ADDR_POWER 4'h9

// ==========================================================
// Field positions
`define BIT_SUM_SEL 0
`define BIT_DAC_SRC 11
`define BIT_EXT_FILTER 11
`define BIT_SCALE 9
`define BIT_BW 8
`define BIT_TEST_ROUTE 11
`define BIT_ONLY_MODE 11
`define BIT_NOISE_ON 9
`define BIT_EQ_ON 8
`define BIT_BOOST 7
`define BIT_PWR 0
`define BIT_IR_LASER 1
`define BIT_RED_LASER 2

// ==========================================================
// Word and serial framing
`define WORD_BITS 16
`define CNT_BITS 5
`define FIELD_ZERO 16'h0000

`endif

// >>> src/servo_rf_pkg.sv
// Types shared by the control register bank
package servo_rf_pkg;
  typedef logic [15:0] word_t;
  typedef logic [3:0] nib_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_LOAD = 3'b100
  } rx_state_e;
  typedef enum logic [1:0] {
    SW_PASS = 2'b00,
    SW_INV = 2'b01,
    SW_MUTE = 2'b10
  } sw_mode_e;
endpackage : servo_rf_pkg

// >>> src/pin_sync3.sv
// Three-stage synchroniser for one pin, change taken when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Pin and clean level
  input wire logic i_pin,
  output logic o_level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // ==========================================================
  // Stable level: update only when the last two stages agree
  always_comb begin
    next_level = o_level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  // Shift chain; first stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      o_level <= next_level;
    end
  end
endmodule : pin_sync3

// >>> src/servo_rf_filter_control_regs.sv
// Serially written control register bank for the servo, RF filter and phase-detector settings
`timescale 1ns/1ps
`include "servo_rf_defines.svh"
module servo_rf_filter_control_regs (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Serial control bus (pins, asynchronous to i_mclk)
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_ser_latch,
  // External digital modifiers and laser state
  input wire logic i_ext_force_standby,
  input wire logic i_infrared_laser_req,
  input wire logic i_red_laser_req,
  // Radial servo settings
  output logic o_track_count_bw_select,
  output logic o_servo_offset_scale,
  output servo_rf_pkg::nib_t o_radial_offset_e,
  output servo_rf_pkg::nib_t o_radial_offset_f,
  output logic [1:0] o_lf_offset,
  // Central servo settings
  output logic o_phase_rf_test_route,
  output logic [2:0] o_servo_test_select,
  output servo_rf_pkg::nib_t o_central_offset_a,
  output servo_rf_pkg::nib_t o_central_offset_b,
  output servo_rf_pkg::nib_t o_central_offset_c,
  output servo_rf_pkg::nib_t o_central_offset_d,
  // Servo output enables, low while driving, and the RF path active flag, high while powered
  output logic [3:0] o_central_out_oe_n,
  output logic o_radial_out_one_oe_n,
  output logic o_radial_out_two_oe_n,
  output logic o_rf_path_active,
  // RF filter settings
  output logic o_noise_filter_on,
  output logic o_equalizer_on,
  output logic o_boost_select,
  output logic [6:0] o_rf_corner_code,
  // Phase-detector filter settings
  output logic [2:0] o_phase_leadlag_start,
  output logic [2:0] o_phase_lowpass_corner,
  // Data path and power
  output logic [7:0] o_channel_switch,
  output logic o_sum_input_select,
  output logic o_offset_dac_source_select,
  output logic [5:0] o_dac_left,
  output logic [5:0] o_dac_sum,
  output logic o_power_on_control,
  output logic o_infrared_laser_on_status,
  output logic o_red_laser_on_status
);
  import servo_rf_pkg::*;

  // ==========================================================
  // Serial pins into the clock domain
  logic ser_clk;
  logic ser_data;
  logic ser_latch;
  logic ser_clk_d;
  logic ser_latch_d;

  pin_sync3 u_sync_clk (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_ser_clk),
    .o_level(ser_clk)
  );
  pin_sync3 u_sync_data (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_ser_data),
    .o_level(ser_data)
  );
  pin_sync3 u_sync_latch (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_ser_latch),
    .o_level(ser_latch)
  );

  // Modifier pins need the same filtering
  logic ext_standby;
  logic ir_req;
  logic red_req;
  pin_sync3 u_sync_stby (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_ext_force_standby),
    .o_level(ext_standby)
  );
  pin_sync3 u_sync_ir (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_infrared_laser_req),
    .o_level(ir_req)
  );
  pin_sync3 u_sync_red (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_red_laser_req),
    .o_level(red_req)
  );

  // ==========================================================
  // Word receiver: MSB first, shifted on rising serial clock, loaded on latch rise
  rx_state_e state;
  rx_state_e next_state;
  word_t shreg;
  word_t next_shreg;
  logic [`CNT_BITS-1:0] bit_cnt;
  logic [`CNT_BITS-1:0] next_bit_cnt;
  logic load;
  logic next_load;
  logic clk_rise;
  logic latch_rise;

  assign clk_rise = ser_clk && !ser_clk_d;
  assign latch_rise = ser_latch && !ser_latch_d;

  // A word of the wrong length is dropped rather than half-applied
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_load = 1'b0;
    case (state)
      ST_IDLE: begin
        next_bit_cnt = '0;
        if (clk_rise) begin
          next_shreg = {shreg[14:0], ser_data};
          next_bit_cnt = 5'd1;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (clk_rise) begin
          next_shreg = {shreg[14:0], ser_data};
          next_bit_cnt = bit_cnt + 5'd1;
        end
        if (latch_rise) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_load = (bit_cnt == 5'd`WORD_BITS);
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      shreg <= `FIELD_ZERO;
      bit_cnt <= '0;
      load <= 1'b0;
      ser_clk_d <= 1'b0;
      ser_latch_d <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      load <= next_load;
      ser_clk_d <= ser_clk;
      ser_latch_d <= ser_latch;
    end
  end

  // ==========================================================
  // Register bank, one write-only word per address
  function automatic logic hit(input word_t w, input nib_t a);
    hit = (w[15:12] == a);
  endfunction : hit

  word_t r_sel;
  word_t r_focus;
  word_t r_lr;
  word_t r_sum;
  word_t r_sw;
  word_t r_rad;
  word_t r_cab;
  word_t r_ccd;
  word_t r_rff;
  word_t r_pdf;
  word_t r_pwr;
  word_t next_sel;
  word_t next_focus;
  word_t next_lr;
  word_t next_sum;
  word_t next_sw;
  word_t next_rad;
  word_t next_cab;
  word_t next_ccd;
  word_t next_rff;
  word_t next_pdf;
  word_t next_pwr;

  // Only data bits are kept; unused bits are masked off on write
  always_comb begin
    next_sel = r_sel;
    next_focus = r_focus;
    next_lr = r_lr;
    next_sum = r_sum;
    next_sw = r_sw;
    next_rad = r_rad;
    next_cab = r_cab;
    next_ccd = r_ccd;
    next_rff = r_rff;
    next_pdf = r_pdf;
    next_pwr = r_pwr;
    if (load) begin
      if (hit(shreg, `ADDR_RF_GAIN_SEL)) next_sel = shreg & 16'h093F;
      if (hit(shreg, `ADDR_FOCUS_OFFSET)) next_focus = shreg & 16'h0FE0;
      if (hit(shreg, `ADDR_RF_OFFS_LR)) next_lr = shreg & 16'h0FFF;
      if (hit(shreg, `ADDR_RF_OFFS_SUM)) next_sum = shreg & 16'h003F;
      if (hit(shreg, `ADDR_CHAN_SWITCH)) next_sw = shreg & 16'h00FF;
      if (hit(shreg, `ADDR_RADIAL)) next_rad = shreg & 16'h0FFF;
      if (hit(shreg, `ADDR_CENTRAL_AB)) next_cab = shreg & 16'h0FFF;
      if (hit(shreg, `ADDR_CENTRAL_CD)) next_ccd = shreg & 16'h08FF;
      if (hit(shreg, `ADDR_RF_FILTER)) next_rff = shreg & 16'h03FF;
      if (hit(shreg, `ADDR_PHASE_FILTER)) next_pdf = shreg & 16'h003F;
      if (hit(shreg, `ADDR_POWER)) next_pwr = shreg & 16'h0007;
    end
  end

  // Everything clears at reset, power control included, so the part starts in standby
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_sel <= `FIELD_ZERO;
      r_focus <= `FIELD_ZERO;
      r_lr <= `FIELD_ZERO;
      r_sum <= `FIELD_ZERO;
      r_sw <= `FIELD_ZERO;
      r_rad <= `FIELD_ZERO;
      r_cab <= `FIELD_ZERO;
      r_ccd <= `FIELD_ZERO;
      r_rff <= `FIELD_ZERO;
      r_pdf <= `FIELD_ZERO;
      r_pwr <= `FIELD_ZERO;
    end else begin
      r_sel <= next_sel;
      r_focus <= next_focus;
      r_lr <= next_lr;
      r_sum <= next_sum;
      r_sw <= next_sw;
      r_rad <= next_rad;
      r_cab <= next_cab;
      r_ccd <= next_ccd;
      r_rff <= next_rff;
      r_pdf <= next_pdf;
      r_pwr <= next_pwr;
    end
  end

  // ==========================================================
  // Derived settings, all registered so outputs come from flip-flops
  logic ext_mode;
  logic pwr;
  logic tri_state;
  assign ext_mode = r_focus[`BIT_EXT_FILTER];
  assign pwr = r_pwr[`BIT_PWR] && !ext_standby;
  assign tri_state = r_ccd[`BIT_ONLY_MODE];

  // Switch code per channel: mute wins over invert
  function automatic logic [1:0] sw_code(input logic mute, input logic inv);
    sw_code = mute ? SW_MUTE : (inv ? SW_INV : SW_PASS);
  endfunction : sw_code

  logic [7:0] next_chsw;
  always_comb begin
    next_chsw = '0;
    for (int i = 0; i < 4; i++) begin
      next_chsw[2*i +: 2] = sw_code(r_sw[2*i+1], r_sw[2*i]);
    end
  end

  // Filter fields fall back to zero outside extended mode, leaving legacy settings in charge
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_track_count_bw_select <= 1'b0;
      o_servo_offset_scale <= 1'b0;
      o_radial_offset_e <= '0;
      o_radial_offset_f <= '0;
      o_lf_offset <= '0;
      o_phase_rf_test_route <= 1'b0;
      o_servo_test_select <= '0;
      o_central_offset_a <= '0;
      o_central_offset_b <= '0;
      o_central_offset_c <= '0;
      o_central_offset_d <= '0;
      o_central_out_oe_n <= 4'hF;
      o_radial_out_one_oe_n <= 1'b1;
      o_radial_out_two_oe_n <= 1'b1;
      o_rf_path_active <= 1'b0;
      o_noise_filter_on <= 1'b0;
      o_equalizer_on <= 1'b0;
      o_boost_select <= 1'b0;
      o_rf_corner_code <= '0;
      o_phase_leadlag_start <= '0;
      o_phase_lowpass_corner <= '0;
      o_channel_switch <= '0;
      o_sum_input_select <= 1'b0;
      o_offset_dac_source_select <= 1'b0;
      o_dac_left <= '0;
      o_dac_sum <= '0;
      o_power_on_control <= 1'b0;
      o_infrared_laser_on_status <= 1'b0;
      o_red_laser_on_status <= 1'b0;
    end else begin
      o_track_count_bw_select <= r_rad[`BIT_BW];
      o_servo_offset_scale <= r_rad[`BIT_SCALE];
      o_radial_offset_e <= r_rad[7:4];
      o_radial_offset_f <= r_rad[3:0];
      o_lf_offset <= r_rad[11:10];
      o_phase_rf_test_route <= r_cab[`BIT_TEST_ROUTE];
      o_servo_test_select <= r_cab[10:8];
      o_central_offset_a <= r_cab[7:4];
      o_central_offset_b <= r_cab[3:0];
      o_central_offset_c <= r_ccd[7:4];
      o_central_offset_d <= r_ccd[3:0];
      // Servo drivers also stay off in standby
      o_central_out_oe_n <= {4{tri_state || !pwr}};
      o_radial_out_one_oe_n <= tri_state || !pwr;
      o_radial_out_two_oe_n <= tri_state || !pwr;
      o_rf_path_active <= pwr;
      o_noise_filter_on <= ext_mode && r_rff[`BIT_NOISE_ON];
      o_equalizer_on <= ext_mode && r_rff[`BIT_EQ_ON];
      o_boost_select <= ext_mode && r_rff[`BIT_BOOST];
      o_rf_corner_code <= ext_mode ? r_rff[6:0] : 7'h00;
      o_phase_leadlag_start <= ext_mode ? r_pdf[5:3] : 3'h0;
      o_phase_lowpass_corner <= ext_mode ? r_pdf[2:0] : 3'h0;
      o_channel_switch <= next_chsw;
      o_sum_input_select <= r_sel[`BIT_SUM_SEL];
      o_offset_dac_source_select <= r_sel[`BIT_DAC_SRC];
      o_dac_left <= r_lr[11:6];
      // Shared DAC value from the low field, or the separate sum register
      o_dac_sum <= r_sel[`BIT_DAC_SRC] ? r_sum[5:0] : r_lr[5:0];
      o_power_on_control <= pwr;
      o_infrared_laser_on_status <= pwr && r_pwr[`BIT_IR_LASER] && ir_req;
      o_red_laser_on_status <= pwr && r_pwr[`BIT_RED_LASER] && red_req;
    end
  end
endmodule : servo_rf_filter_control_regs

// >>> testbench/serial_host_model.sv
// Behavioural host that writes control words over the three-wire serial bus
`timescale 1ns/1ps
module serial_host_model (
  // Clock
  input wire logic i_mclk,
  // Serial bus pins
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_ser_latch
);
  // ==========================================================
  // Idle levels, pins change only on the falling edge of i_mclk
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_latch = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : hold

  // Address nibble first, MSB first; n below 16 makes a short frame on purpose
  task automatic send(input logic [15:0] w, input int n);
    for (int i = 15; i > 15 - n; i--) begin
      o_ser_data = w[i];
      hold(5);
      o_ser_clk = 1'b1;
      hold(5);
      o_ser_clk = 1'b0;
    end
    hold(5);
    // Data is no longer valid, so it flips rather than holding the last bit
    o_ser_data = ~o_ser_data;
    o_ser_latch = 1'b1;
    hold(5);
    o_ser_latch = 1'b0;
    hold(5);
  endtask : send
endmodule : serial_host_model

// >>> testbench/servo_rf_filter_control_regs_assertions.sv
// Port checker for the control register bank
`timescale 1ns/1ps
module servo_rf_filter_control_regs_assertions (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Inputs watched
  input wire logic i_ser_latch,
  input wire logic i_ext_force_standby,
  // Outputs watched
  input wire servo_rf_pkg::nib_t o_radial_offset_e,
  input wire servo_rf_pkg::nib_t o_central_offset_a,
  input wire logic [6:0] o_rf_corner_code,
  input wire logic [3:0] o_central_out_oe_n,
  input wire logic o_radial_out_one_oe_n,
  input wire logic o_rf_path_active,
  input wire logic [7:0] o_channel_switch,
  input wire logic o_power_on_control,
  input wire logic o_infrared_laser_on_status,
  input wire logic o_red_laser_on_status
);
  import servo_rf_pkg::*;
  // ==========================================================
  // Cycles since the latch pin was last high; saturates to stay small
  logic [4:0] quiet;
  logic [4:0] next_quiet;
  always_comb begin
    next_quiet = quiet;
    if (i_ser_latch) begin
      next_quiet = 5'h00;
    end else if (quiet != 5'h1F) begin
      next_quiet = quiet + 5'h01;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      quiet <= 5'h00;
    end else begin
      quiet <= next_quiet;
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  // ==========================================================
  // Properties
  property p_reset_vals;
    $rose(i_rstn) |-> !o_power_on_control && o_central_out_oe_n == 4'hF && o_channel_switch == 8'h00;
  endproperty
  property p_standby_float;
    !o_power_on_control [*2] |-> o_central_out_oe_n == 4'hF && o_radial_out_one_oe_n;
  endproperty
  property p_rf_follows;
    o_rf_path_active == o_power_on_control;
  endproperty
  property p_ir_status;
    o_infrared_laser_on_status |-> o_power_on_control;
  endproperty
  property p_red_status;
    o_red_laser_on_status |-> o_power_on_control;
  endproperty
  property p_sw_code;
    o_channel_switch[1:0] != 2'b11 && o_channel_switch[3:2] != 2'b11 &&
      o_channel_switch[5:4] != 2'b11 && o_channel_switch[7:6] != 2'b11;
  endproperty
  property p_servo_hold;
    quiet > 5'h08 |-> $stable(o_radial_offset_e) && $stable(o_central_offset_a);
  endproperty
  property p_filter_hold;
    quiet > 5'h08 |-> $stable(o_rf_corner_code);
  endproperty
  property p_ext_standby;
    i_ext_force_standby [*8] |-> !o_power_on_control;
  endproperty

  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  a_standby_float: assert property (p_standby_float) else $error("servo outputs driven in standby");
  a_rf_follows: assert property (p_rf_follows) else $error("data path state wrong");
  a_ir_status: assert property (p_ir_status) else $error("infrared status without power");
  a_red_status: assert property (p_red_status) else $error("red status without power");
  a_sw_code: assert property (p_sw_code) else $error("illegal channel switch code");
  a_servo_hold: assert property (p_servo_hold) else $error("offset changed with no word");
  a_filter_hold: assert property (p_filter_hold) else $error("corner changed with no word");
  a_ext_standby: assert property (p_ext_standby) else $error("standby pin ignored");

  c_power: cover property (o_power_on_control);
  c_float_powered: cover property (o_power_on_control && o_central_out_oe_n == 4'hF);
  c_laser: cover property (o_red_laser_on_status && o_infrared_laser_on_status);
endmodule : servo_rf_filter_control_regs_assertions

bind servo_rf_filter_control_regs servo_rf_filter_control_regs_assertions chk_i (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ser_latch(i_ser_latch), .i_ext_force_standby(i_ext_force_standby),
  .o_radial_offset_e(o_radial_offset_e), .o_central_offset_a(o_central_offset_a),
  .o_rf_corner_code(o_rf_corner_code), .o_central_out_oe_n(o_central_out_oe_n),
  .o_radial_out_one_oe_n(o_radial_out_one_oe_n), .o_rf_path_active(o_rf_path_active),
  .o_channel_switch(o_channel_switch), .o_power_on_control(o_power_on_control),
  .o_infrared_laser_on_status(o_infrared_laser_on_status), .o_red_laser_on_status(o_red_laser_on_status)
);

// >>> testbench/test_servo_rf_filter_control_regs.sv
// Self-checking testbench for the control register bank
`timescale 1ns/1ps
module test_servo_rf_filter_control_regs;
  import servo_rf_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ext_force_standby = 1'b0;
  logic i_infrared_laser_req = 1'b0;
  logic i_red_laser_req = 1'b0;
  logic ser_clk, ser_data, ser_latch;
  logic o_bw, o_scale, o_route, o_noise, o_eq, o_boost, o_one, o_two, o_rf, o_sum, o_src, o_pwr, o_ir, o_red;
  nib_t o_e, o_f, o_a, o_b, o_c, o_d;
  logic [1:0] o_lf;
  logic [2:0] o_tsel, o_ll, o_lp;
  logic [3:0] o_oe;
  logic [6:0] o_corner;
  logic [7:0] o_sw;
  logic [5:0] o_dl, o_ds;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  // ==========================================================
  // Clock, far-side model and design
  always #4 i_mclk = ~i_mclk;
  serial_host_model host (.i_mclk(i_mclk), .o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_ser_latch(ser_latch));
  servo_rf_filter_control_regs dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ser_clk(ser_clk), .i_ser_data(ser_data), .i_ser_latch(ser_latch),
    .i_ext_force_standby(i_ext_force_standby), .i_infrared_laser_req(i_infrared_laser_req),
    .i_red_laser_req(i_red_laser_req), .o_track_count_bw_select(o_bw), .o_servo_offset_scale(o_scale),
    .o_radial_offset_e(o_e), .o_radial_offset_f(o_f), .o_lf_offset(o_lf), .o_phase_rf_test_route(o_route),
    .o_servo_test_select(o_tsel), .o_central_offset_a(o_a), .o_central_offset_b(o_b), .o_central_offset_c(o_c),
    .o_central_offset_d(o_d), .o_central_out_oe_n(o_oe), .o_radial_out_one_oe_n(o_one),
    .o_radial_out_two_oe_n(o_two), .o_rf_path_active(o_rf), .o_noise_filter_on(o_noise), .o_equalizer_on(o_eq),
    .o_boost_select(o_boost), .o_rf_corner_code(o_corner), .o_phase_leadlag_start(o_ll),
    .o_phase_lowpass_corner(o_lp), .o_channel_switch(o_sw), .o_sum_input_select(o_sum),
    .o_offset_dac_source_select(o_src), .o_dac_left(o_dl), .o_dac_sum(o_ds), .o_power_on_control(o_pwr),
    .o_infrared_laser_on_status(o_ir), .o_red_laser_on_status(o_red)
  );

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Outputs take 8 cycles after latch rise, so 14 leaves margin
  task automatic wr(input logic [15:0] w);
    host.send(w, 16);
    repeat (14) @(negedge i_mclk);
  endtask : wr

  // Power, status and output-enable group packed into one word
  function automatic logic [15:0] pwr_grp();
    return {o_pwr, o_ir, o_red, o_rf, o_oe, o_one, o_two, 6'h00};
  endfunction : pwr_grp

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(pwr_grp(), 16'h0FC0);
    chk({o_sum, o_src, o_tsel, o_route, 10'h000}, 16'h0000);
    chk({o_a, o_b, o_c, o_d}, 16'h0000);
    chk({o_dl, o_ds, o_e}, 16'h0000);
    $display("reset test done");
  endtask : t_reset

  task automatic t_radial();
    wr(16'hBBA5);
    chk({o_lf, o_scale, o_bw, o_e, o_f, 4'h0}, 16'hBA50);
    wr(16'hB000);
    chk({o_lf, o_scale, o_bw, o_e, o_f, 4'h0}, 16'h0000);
    $display("radial test done");
  endtask : t_radial

  task automatic t_central();
    logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    foreach (codes[i]) begin
      wr({4'hC, 1'b1, codes[i], 8'h3C});
      chk({o_route, o_tsel, o_a, o_b, 4'h0}, {1'b1, codes[i], 8'h3C, 4'h0});
    end
    wr(16'hC000);
    chk({o_route, o_tsel, o_a, o_b, 4'h0}, 16'h0000);
    // Unmapped address, then a short frame that would shift in as CFFF if it were loaded
    wr(16'h7FFF);
    host.send(16'h9FFF, 15);
    repeat (14) @(negedge i_mclk);
    chk({o_route, o_tsel, o_a, o_b, 4'h0}, 16'h0000);
    $display("central test done");
  endtask : t_central

  task automatic t_power();
    i_infrared_laser_req = 1'b1;
    i_red_laser_req = 1'b1;
    wr(16'h9007);
    chk(pwr_grp(), 16'hF000);
    wr(16'hD87E);
    chk(pwr_grp(), 16'hFFC0);
    chk({o_c, o_d, 8'h00}, 16'h7E00);
    wr(16'hD000);
    chk(pwr_grp(), 16'hF000);
    i_red_laser_req = 1'b0;
    repeat (8) @(negedge i_mclk);
    chk(pwr_grp(), 16'hD000);
    i_ext_force_standby = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk(pwr_grp(), 16'h0FC0);
    i_ext_force_standby = 1'b0;
    repeat (8) @(negedge i_mclk);
    chk(pwr_grp(), 16'hD000);
    $display("power test done");
  endtask : t_power

  task automatic t_filter();
    wr(16'hEFFF);
    wr(16'hF027);
    chk({o_noise, o_eq, o_boost, o_corner, o_ll, o_lp}, 16'h0000);
    wr(16'h2800);
    chk({o_noise, o_eq, o_boost, o_corner, o_ll, o_lp}, 16'hFFE7);
    wr(16'hE200);
    chk({o_noise, o_eq, o_boost, o_corner, o_ll, o_lp}, 16'h8027);
    wr(16'h2000);
    chk({o_noise, o_eq, o_boost, o_corner, o_ll, o_lp}, 16'h0000);
    $display("filter test done");
  endtask : t_filter

  task automatic t_switch();
    // A pass, B invert, C mute, D mute with invert where mute wins
    wr(16'h80E4);
    chk({8'h00, o_sw}, 16'h00A4);
    wr(16'h1801);
    wr(16'h4A95);
    wr(16'h5033);
    chk({o_sum, o_src, o_dl, o_ds, 2'b00}, 16'hEACC);
    wr(16'h1001);
    chk({o_sum, o_src, o_dl, o_ds, 2'b00}, 16'hAA54);
    $display("switch test done");
  endtask : t_switch

  // ==========================================================
  // Hang guard and main sequence
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    repeat (8) @(negedge i_mclk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_mclk);
    t_reset();
    t_radial();
    t_central();
    t_power();
    t_filter();
    t_switch();
    complete_run();
  end
endmodule : test_servo_rf_filter_control_regs
